// >>> rtl/line_quality_monitor.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "lqm_defines.svh"
module line_quality_monitor
  import lqm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic zero_cross_pulse,
  input wire logic [15:0] filtered_voltage,
  input wire logic filtered_voltage_valid,
  input wire logic [23:0] voltage_wave_sample,
  input wire logic [23:0] current_wave_sample,
  input wire logic wave_sample_valid,
  output logic measurement_interrupt,
  output logic supply_monitor_interrupt
);

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Bus decode
  logic [7:0] bus_index;
  logic [31:0] write_mask;
  logic bus_request;
  logic bus_write;
  logic bus_read;
  assign bus_index = wb_adr_i[9:2];
  assign write_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign bus_request = wb_cyc_i & wb_stb_i;
  // Writes and read side effects land on the edge where the master sees ack
  assign bus_write = bus_request & wb_ack_o & wb_we_i;
  assign bus_read = bus_request & wb_ack_o & ~wb_we_i;

  function automatic logic [31:0] merge_write(input logic [31:0] old_value);
    merge_write = (old_value & ~write_mask) | (wb_dat_i & write_mask);
  endfunction

  wire logic write_mode = bus_write && (bus_index == `LQM_IDX_SECOND_MODE);
  wire logic write_reload = bus_write && (bus_index == `LQM_IDX_ZX_TIMEOUT);
  wire logic write_sag_level = bus_write && (bus_index == `LQM_IDX_SAG_LEVEL);
  wire logic write_sag_cycles = bus_write && (bus_index == `LQM_IDX_SAG_CYCLES);
  wire logic write_vpk_level = bus_write && (bus_index == `LQM_IDX_VOLTAGE_PEAK_RECORD_LEVEL);
  wire logic write_ipk_level = bus_write && (bus_index == `LQM_IDX_CURRENT_PEAK_RECORD_LEVEL);
  wire logic write_meas_en = bus_write && (bus_index == `LQM_IDX_MEAS_ENABLE);
  wire logic write_meas_st = bus_write && (bus_index == `LQM_IDX_MEAS_STATUS);
  wire logic write_sup_en = bus_write && (bus_index == `LQM_IDX_SUPPLY_ENABLE);
  wire logic write_sup_fl = bus_write && (bus_index == `LQM_IDX_SUPPLY_FLAGS);
  wire logic clear_voltage_peak_record = bus_read && (bus_index == `LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD_CLR);
  wire logic clear_current_peak_record = bus_read && (bus_index == `LQM_IDX_CURRENT_PEAK_RECORD_RECORD_CLR);

  // Software registers
  logic [7:0] second_mode_register;
  logic [11:0] zero_cross_timeout_reload;
  logic [15:0] sag_threshold_level;
  logic [7:0] sag_cycle_count;
  logic [15:0] voltage_peak_threshold;
  logic [15:0] current_peak_threshold;
  logic [7:0] measurement_irq_enable_three;
  logic [7:0] measurement_irq_status_three;
  logic [7:0] supply_monitor_irq_enable;
  logic [7:0] supply_monitor_irq_flags;
  logic [15:0] line_period_or_frequency;
  logic [23:0] voltage_peak_record;
  logic [23:0] current_peak_record;

  logic [31:0] merged_mode;
  logic [31:0] merged_reload;
  logic [31:0] merged_sag_level;
  logic [31:0] merged_sag_cycles;
  logic [31:0] merged_vpk;
  logic [31:0] merged_ipk;
  logic [31:0] merged_meas_en;
  logic [31:0] merged_sup_en;
  // A process, not assigns: the merge reads bus data and lanes outside its arguments
  always_comb begin
    merged_mode = merge_write({24'h000000, second_mode_register});
    merged_reload = merge_write({20'h00000, zero_cross_timeout_reload});
    merged_sag_level = merge_write({16'h0000, sag_threshold_level});
    merged_sag_cycles = merge_write({24'h000000, sag_cycle_count});
    merged_vpk = merge_write({16'h0000, voltage_peak_threshold});
    merged_ipk = merge_write({16'h0000, current_peak_threshold});
    merged_meas_en = merge_write({24'h000000, measurement_irq_enable_three});
    merged_sup_en = merge_write({24'h000000, supply_monitor_irq_enable});
  end

  wire logic freq_select = second_mode_register[`LQM_BIT_FREQ_SELECT];

  always_ff @(posedge clock) begin
    if (reset) begin
      second_mode_register <= `LQM_RESET_BYTE;
      zero_cross_timeout_reload <= `LQM_RESET_TIMEOUT_RELOAD;
      sag_threshold_level <= `LQM_RESET_SAG_LEVEL;
      sag_cycle_count <= `LQM_RESET_SAG_CYCLES;
    end else begin
      if (write_mode) second_mode_register <= merged_mode[7:0];
      if (write_reload) zero_cross_timeout_reload <= merged_reload[11:0];
      if (write_sag_level) sag_threshold_level <= merged_sag_level[15:0];
      if (write_sag_cycles) sag_cycle_count <= merged_sag_cycles[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      voltage_peak_threshold <= `LQM_RESET_PEAK_LEVEL;
      current_peak_threshold <= `LQM_RESET_PEAK_LEVEL;
      measurement_irq_enable_three <= `LQM_RESET_BYTE;
      supply_monitor_irq_enable <= `LQM_RESET_BYTE;
    end else begin
      if (write_vpk_level) voltage_peak_threshold <= merged_vpk[15:0];
      if (write_ipk_level) current_peak_threshold <= merged_ipk[15:0];
      if (write_meas_en) measurement_irq_enable_three <= merged_meas_en[7:0];
      if (write_sup_en) supply_monitor_irq_enable <= merged_sup_en[7:0];
    end
  end

  // Zero-crossing timeout
  logic [7:0] timeout_prescale;
  logic [11:0] timeout_count;
  logic timeout_tick;
  logic timeout_event;
  assign timeout_tick = (timeout_prescale == `LQM_TIMEOUT_TICK_LAST);
  // A reload on the same edge beats the last decrement, so no false alarm
  assign timeout_event = timeout_tick && !zero_cross_pulse && !write_reload &&
                         (timeout_count == 12'h001);

  always_ff @(posedge clock) begin
    if (reset || timeout_tick) timeout_prescale <= 8'h00;
    else timeout_prescale <= timeout_prescale + 8'h01;
  end

  always_ff @(posedge clock) begin
    if (reset) timeout_count <= `LQM_RESET_TIMEOUT_RELOAD;
    else if (write_reload) timeout_count <= merged_reload[11:0];
    else if (zero_cross_pulse) timeout_count <= zero_cross_timeout_reload;
    else if (timeout_tick && timeout_count != 12'h000) timeout_count <= timeout_count - 12'h001;
  end

  // Line crossing and period measurement
  logic voltage_negative;
  logic rising_crossing;
  logic [3:0] period_prescale;
  logic [15:0] period_count;
  wire logic period_tick = (period_prescale == `LQM_PERIOD_TICK_LAST);
  assign rising_crossing = filtered_voltage_valid && voltage_negative &&
                           !filtered_voltage[15];

  always_ff @(posedge clock) begin
    if (reset) voltage_negative <= 1'b0;
    else if (filtered_voltage_valid) voltage_negative <= filtered_voltage[15];
  end

  always_ff @(posedge clock) begin
    if (reset || period_tick) period_prescale <= 4'h0;
    else period_prescale <= period_prescale + 4'h1;
  end

  // Saturates so a line below the measurable range reads full scale in period mode; frequency mode then reads 100
  always_ff @(posedge clock) begin
    if (reset || rising_crossing) period_count <= 16'h0000;
    else if (period_tick && period_count != 16'hffff) period_count <= period_count + 16'h0001;
  end

  // Frequency by serial division: one quotient bit per clock keeps it small
  div_state_t div_state;
  logic [22:0] div_quotient;
  logic [15:0] div_remainder;
  logic [15:0] div_divisor;
  logic [4:0] div_steps;
  logic [16:0] div_shifted;
  logic [16:0] div_reduced;
  logic div_fits;
  logic [15:0] div_result;
  wire logic div_start = rising_crossing && freq_select;
  assign div_shifted = {div_remainder, div_quotient[22]};
  assign div_reduced = div_shifted - {1'b0, div_divisor};
  assign div_fits = (div_shifted >= {1'b0, div_divisor});
  assign div_result = (|div_quotient[22:16]) ? 16'hffff : div_quotient[15:0];

  always_ff @(posedge clock) begin
    if (reset) begin
      div_state <= DIV_IDLE;
      div_quotient <= 23'h000000;
      div_remainder <= 16'h0000;
      div_divisor <= 16'h0000;
      div_steps <= 5'h00;
    end else if (div_start) begin
      div_state <= DIV_RUN;
      div_quotient <= `LQM_FREQ_NUMERATOR;
      div_remainder <= 16'h0000;
      div_divisor <= period_count;
      div_steps <= 5'h00;
    end else begin
      case (div_state)
        DIV_IDLE: begin
          div_state <= DIV_IDLE;
        end
        DIV_RUN: begin
          div_quotient <= {div_quotient[21:0], div_fits};
          div_remainder <= div_fits ? div_reduced[15:0] : div_shifted[15:0];
          div_steps <= div_steps + 5'h01;
          if (div_steps == `LQM_DIV_LAST_STEP) div_state <= DIV_DONE;
        end
        DIV_DONE: begin
          div_state <= DIV_IDLE;
        end
        default: begin
          div_state <= DIV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) line_period_or_frequency <= 16'h0000;
    else if (rising_crossing && !freq_select) line_period_or_frequency <= period_count;
    else if (div_state == DIV_DONE) line_period_or_frequency <= div_result;
  end

  // Sag detection
  logic [15:0] abs_filtered;
  logic below_level;
  logic cycle_all_below;
  logic [7:0] sag_cycles;
  logic [7:0] next_sag_cycles;
  logic sag_event;
  assign abs_filtered = filtered_voltage[15] ? (~filtered_voltage + 16'h0001) : filtered_voltage;
  assign below_level = (sag_threshold_level > abs_filtered);
  assign next_sag_cycles = !cycle_all_below ? 8'h00 :
                           (sag_cycles == 8'hff) ? 8'hff : sag_cycles + 8'h01;
  assign sag_event = rising_crossing && cycle_all_below &&
                     (next_sag_cycles == sag_cycle_count - 8'h01);

  always_ff @(posedge clock) begin
    if (reset) cycle_all_below <= 1'b1;
    else if (rising_crossing) cycle_all_below <= below_level;
    else if (filtered_voltage_valid && !below_level) cycle_all_below <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (reset) sag_cycles <= 8'h00;
    else if (rising_crossing) sag_cycles <= next_sag_cycles;
  end

  // Peak detection, both channels in parallel
  logic [23:0] abs_voltage;
  logic [23:0] abs_current;
  logic voltage_over;
  logic current_over;
  logic [23:0] voltage_peak_record_base;
  logic [23:0] current_peak_record_base;
  assign abs_voltage = voltage_wave_sample[23] ? (~voltage_wave_sample + 24'h000001)
                                               : voltage_wave_sample;
  assign abs_current = current_wave_sample[23] ? (~current_wave_sample + 24'h000001)
                                               : current_wave_sample;
  assign voltage_over = wave_sample_valid &&
                        (abs_voltage[23:8] > voltage_peak_threshold);
  assign current_over = wave_sample_valid &&
                        (abs_current[23:8] > current_peak_threshold);
  assign voltage_peak_record_base = clear_voltage_peak_record ? 24'h000000 : voltage_peak_record;
  assign current_peak_record_base = clear_current_peak_record ? 24'h000000 : current_peak_record;

  // A sample arriving with the clearing read still gets recorded
  always_ff @(posedge clock) begin
    if (reset) begin
      voltage_peak_record <= 24'h000000;
      current_peak_record <= 24'h000000;
    end else begin
      voltage_peak_record <= (wave_sample_valid && abs_voltage > voltage_peak_record_base) ?
                             abs_voltage : voltage_peak_record_base;
      current_peak_record <= (wave_sample_valid && abs_current > current_peak_record_base) ?
                             abs_current : current_peak_record_base;
    end
  end

  // Status flags: software writes zero to clear, and a new event wins
  logic [7:0] set_measure;
  logic [7:0] clear_measure;
  logic [7:0] set_supply;
  logic [7:0] clear_supply;
  always_comb begin
    set_measure = 8'h00;
    set_measure[`LQM_BIT_TIMEOUT] = timeout_event;
    set_measure[`LQM_BIT_VOLTAGE_PEAK] = voltage_over;
    set_measure[`LQM_BIT_CURRENT_PEAK] = current_over;
    set_supply = 8'h00;
    set_supply[`LQM_BIT_SAG] = sag_event;
  end
  assign clear_measure = (write_meas_st && wb_sel_i[0]) ? ~wb_dat_i[7:0] : 8'h00;
  assign clear_supply = (write_sup_fl && wb_sel_i[0]) ? ~wb_dat_i[7:0] : 8'h00;

  always_ff @(posedge clock) begin
    if (reset) begin
      measurement_irq_status_three <= `LQM_RESET_BYTE;
      supply_monitor_irq_flags <= `LQM_RESET_BYTE;
    end else begin
      measurement_irq_status_three <= (measurement_irq_status_three & ~clear_measure) |
                                      set_measure;
      supply_monitor_irq_flags <= (supply_monitor_irq_flags & ~clear_supply) |
                                  set_supply;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      measurement_interrupt <= 1'b0;
      supply_monitor_interrupt <= 1'b0;
    end else begin
      measurement_interrupt <= |(measurement_irq_status_three &
                                 measurement_irq_enable_three);
      supply_monitor_interrupt <= |(supply_monitor_irq_flags &
                                    supply_monitor_irq_enable);
    end
  end

  // Read side; unmapped addresses answer with zero
  logic [31:0] read_value;
  always_comb begin
    case (bus_index)
      `LQM_IDX_PERIOD_FREQ: read_value = {16'h0000, line_period_or_frequency};
      `LQM_IDX_SECOND_MODE: read_value = {24'h000000, second_mode_register};
      `LQM_IDX_ZX_TIMEOUT: read_value = {20'h00000, zero_cross_timeout_reload};
      `LQM_IDX_SAG_LEVEL: read_value = {16'h0000, sag_threshold_level};
      `LQM_IDX_SAG_CYCLES: read_value = {24'h000000, sag_cycle_count};
      `LQM_IDX_VOLTAGE_PEAK_RECORD_LEVEL: read_value = {16'h0000, voltage_peak_threshold};
      `LQM_IDX_CURRENT_PEAK_RECORD_LEVEL: read_value = {16'h0000, current_peak_threshold};
      `LQM_IDX_CURRENT_PEAK_RECORD_RECORD: read_value = {8'h00, current_peak_record};
      `LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD: read_value = {8'h00, voltage_peak_record};
      `LQM_IDX_CURRENT_PEAK_RECORD_RECORD_CLR: read_value = {8'h00, current_peak_record};
      `LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD_CLR: read_value = {8'h00, voltage_peak_record};
      `LQM_IDX_MEAS_ENABLE: read_value = {24'h000000, measurement_irq_enable_three};
      `LQM_IDX_MEAS_STATUS: read_value = {24'h000000, measurement_irq_status_three};
      `LQM_IDX_SUPPLY_ENABLE: read_value = {24'h000000, supply_monitor_irq_enable};
      `LQM_IDX_SUPPLY_FLAGS: read_value = {24'h000000, supply_monitor_irq_flags};
      default: read_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_request && !wb_ack_o;
      if (bus_request && !wb_ack_o) wb_dat_o <= read_value;
    end
  end

  // Checks
  AST_RELOAD_AT_RESET: assert property (
    $fell(reset) |-> zero_cross_timeout_reload == `LQM_RESET_TIMEOUT_RELOAD)
    else $error("timeout reload not all ones after reset");

  AST_TIMEOUT_DECREMENT: assert property (
    timeout_tick && !zero_cross_pulse && !write_reload && timeout_count != 12'h000
    |=> timeout_count == $past(timeout_count) - 12'h001)
    else $error("timeout counter did not step down on tick");

  AST_TIMEOUT_TICK_SPACING: assert property (
    timeout_tick |-> ##160 timeout_tick)
    else $error("timeout tick spacing is not 160 clocks");

  AST_TIMEOUT_FLAG: assert property (
    timeout_count == 12'h001 && timeout_tick && !zero_cross_pulse && !write_reload
    |=> measurement_irq_status_three[`LQM_BIT_TIMEOUT] ##0 timeout_count == 12'h000)
    else $error("timeout flag not set at zero");

  AST_TIMEOUT_IRQ_HOLD: assert property (
    measurement_irq_status_three[`LQM_BIT_TIMEOUT] &&
    measurement_irq_enable_three[`LQM_BIT_TIMEOUT] |=> measurement_interrupt)
    else $error("timeout interrupt dropped while flag set");

  AST_PERIOD_LATCH: assert property (
    rising_crossing && !freq_select |=> line_period_or_frequency == $past(period_count))
    else $error("period result not latched at crossing");

  AST_FREQ_DONE: assert property (
    div_start ##1 (!div_start) [*8] |-> ##16 div_state == DIV_DONE)
    else $error("frequency division did not finish in time");

  AST_SAG_FLAG: assert property (
    sag_event |=> supply_monitor_irq_flags[`LQM_BIT_SAG] && sag_cycles == sag_cycle_count - 8'h01)
    else $error("sag flag not set at count minus one cycles");

  AST_SAG_COMPARE: assert property (
    filtered_voltage_valid && !rising_crossing && sag_threshold_level <= abs_filtered
    |=> !cycle_all_below)
    else $error("sample at or above sag level not seen");

  AST_SAG_IRQ: assert property (
    supply_monitor_irq_flags[`LQM_BIT_SAG] && supply_monitor_irq_enable[`LQM_BIT_SAG]
    |=> supply_monitor_interrupt)
    else $error("supply monitor interrupt missing");

  AST_PEAK_STRICT: assert property (
    wave_sample_valid && abs_voltage[23:8] == voltage_peak_threshold &&
    !measurement_irq_status_three[`LQM_BIT_VOLTAGE_PEAK]
    |=> !measurement_irq_status_three[`LQM_BIT_VOLTAGE_PEAK])
    else $error("voltage peak flag set on equal sample");

  AST_PEAK_IRQ: assert property (
    current_over && measurement_irq_enable_three[`LQM_BIT_CURRENT_PEAK]
    |=> ##1 measurement_interrupt)
    else $error("current peak interrupt missing");

  AST_RECORD_GROWS: assert property (
    wave_sample_valid && !clear_voltage_peak_record && abs_voltage > voltage_peak_record
    |=> voltage_peak_record == $past(abs_voltage))
    else $error("voltage peak record not updated");

  AST_RECORD_CLEAR: assert property (
    clear_current_peak_record && !wave_sample_valid |=> current_peak_record == 24'h000000)
    else $error("current peak record not cleared by read");

endmodule

// >>> rtl/lqm_defines.svh
`ifndef LQM_DEFINES_SVH
`define LQM_DEFINES_SVH

// Register indices; byte address is four times the index
`define LQM_IDX_PERIOD_FREQ 8'h0a
`define LQM_IDX_SECOND_MODE 8'h0c
`define LQM_IDX_ZX_TIMEOUT 8'h11
`define LQM_IDX_SAG_LEVEL 8'h14
`define LQM_IDX_SAG_CYCLES 8'h20
`define LQM_IDX_VOLTAGE_PEAK_RECORD_LEVEL 8'h21
`define LQM_IDX_CURRENT_PEAK_RECORD_LEVEL 8'h22
`define LQM_IDX_CURRENT_PEAK_RECORD_RECORD 8'h23
`define LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD 8'h24
`define LQM_IDX_CURRENT_PEAK_RECORD_RECORD_CLR 8'h25
`define LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD_CLR 8'h26
`define LQM_IDX_MEAS_ENABLE 8'hdb
`define LQM_IDX_MEAS_STATUS 8'hde
`define LQM_IDX_SUPPLY_ENABLE 8'hec
`define LQM_IDX_SUPPLY_FLAGS 8'hf8

// Bit positions
`define LQM_BIT_FREQ_SELECT 0
`define LQM_BIT_TIMEOUT 0
`define LQM_BIT_VOLTAGE_PEAK 1
`define LQM_BIT_CURRENT_PEAK 2
`define LQM_BIT_SAG 0

// Reset values
`define LQM_RESET_TIMEOUT_RELOAD 12'hfff
`define LQM_RESET_SAG_LEVEL 16'h0000
`define LQM_RESET_SAG_CYCLES 8'hff
`define LQM_RESET_PEAK_LEVEL 16'hffff
`define LQM_RESET_BYTE 8'h00

// Timing, in master clock periods, and frequency scaling
`define LQM_TIMEOUT_TICK_PERIODS 160
`define LQM_TIMEOUT_TICK_LAST 8'd159
`define LQM_PERIOD_TICK_LAST 4'd9
`define LQM_NOMINAL_MCLK_HZ 4096000
`define LQM_FREQ_STEPS_PER_HZ 16
`define LQM_PERIOD_UNIT 10
`define LQM_FREQ_NUMERATOR \
  23'(`LQM_NOMINAL_MCLK_HZ * `LQM_FREQ_STEPS_PER_HZ / `LQM_PERIOD_UNIT)
`define LQM_DIV_LAST_STEP 5'd22

`endif

// >>> rtl/lqm_pkg.sv
package lqm_pkg;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN = 2'b01,
    DIV_DONE = 2'b11
  } div_state_t;
endpackage

// >>> verification/line_source.sv
`timescale 1ns/100ps
module line_source (
  input wire logic clock,
  input wire logic reset,
  input wire logic running,
  output logic [15:0] filtered_voltage,
  output logic filtered_voltage_valid,
  output logic zero_cross_pulse
);
  // Square line of 2000 clocks; a stopped line sits at a positive dc level
  logic [10:0] phase;
  always_ff @(posedge clock) begin
    if (reset || !running || phase == 11'd1999) phase <= '0;
    else phase <= phase + 11'd1;
  end
  assign filtered_voltage = (phase < 11'd1000) ? 16'h1000 : 16'hf000;
  assign filtered_voltage_valid = (phase % 11'd10) == 11'd0;
  assign zero_cross_pulse = running && (phase == 11'd0 || phase == 11'd1000);
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`include "lqm_defines.svh"
module tb_top;
  logic clock, reset, cyc, stb, we, ack, wv, mi, si, fvv, zx, run;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, rd;
  logic [23:0] vs, is;
  logic [15:0] fv;
  int failures, cmp_count;
  line_source SRC(.clock(clock), .reset(reset), .running(run), .filtered_voltage(fv),
    .filtered_voltage_valid(fvv), .zero_cross_pulse(zx));
  line_quality_monitor DUT(.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .zero_cross_pulse(zx), .filtered_voltage(fv),
    .filtered_voltage_valid(fvv), .voltage_wave_sample(vs), .current_wave_sample(is),
    .wave_sample_valid(wv), .measurement_interrupt(mi), .supply_monitor_interrupt(si));
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input logic [31:0] got, exp);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for ack as long as it takes; only the watchdog ends a hung request
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= {idx, 2'b00};
    wd <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, '0);
    check(rd === exp, rd, exp);
  endtask
  task automatic sample(input logic [23:0] v, i);
    @(posedge clock);
    vs <= v;
    is <= i;
    wv <= 1'b1;
    @(posedge clock);
    wv <= 1'b0;
  endtask
  // Bounded wait on one interrupt line, then compare it with the expected level
  task automatic irq_chk(input logic sup, input int lim, input logic exp);
    int n;
    for (n = 0; n < lim && (sup ? si : mi) !== exp; n++) @(posedge clock);
    check((sup ? si : mi) === exp, sup ? si : mi, exp);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end
  initial begin
    {reset, cyc, stb, we, wv, run, adr, sel, wd, vs, is} = '0;
    reset = 1'b1;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd_chk(`LQM_IDX_ZX_TIMEOUT, 32'h00000fff);
    rd_chk(8'h30, 32'h0);
    bus(`LQM_IDX_MEAS_ENABLE, 1'b1, 32'h7);
    bus(`LQM_IDX_ZX_TIMEOUT, 1'b1, 32'h002);
    repeat (150) @(posedge clock);
    check(mi === 1'b0, mi, 32'h0);
    irq_chk(1'b0, 400, 1'b1);
    rd_chk(`LQM_IDX_ZX_TIMEOUT, 32'h002);
    rd_chk(`LQM_IDX_MEAS_STATUS, 32'h1);
    bus(`LQM_IDX_MEAS_STATUS, 1'b1, 32'h0);
    irq_chk(1'b0, 3, 1'b0);
    $display("Test timeout done");
    run <= 1'b1;
    bus(`LQM_IDX_ZX_TIMEOUT, 1'b1, 32'hfff);
    bus(`LQM_IDX_VOLTAGE_PEAK_RECORD_LEVEL, 1'b1, 32'h10);
    bus(`LQM_IDX_CURRENT_PEAK_RECORD_LEVEL, 1'b1, 32'h20);
    sample(24'h001000, 24'h002000);
    rd_chk(`LQM_IDX_MEAS_STATUS, 32'h0);
    sample(24'hffef00, 24'h002100);
    rd_chk(`LQM_IDX_MEAS_STATUS, 32'h6);
    irq_chk(1'b0, 3, 1'b1);
    rd_chk(`LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD, 32'h1100);
    rd_chk(`LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD_CLR, 32'h1100);
    rd_chk(`LQM_IDX_VOLTAGE_PEAK_RECORD_RECORD, 32'h0);
    rd_chk(`LQM_IDX_CURRENT_PEAK_RECORD_RECORD_CLR, 32'h2100);
    rd_chk(`LQM_IDX_CURRENT_PEAK_RECORD_RECORD, 32'h0);
    bus(`LQM_IDX_MEAS_STATUS, 1'b1, 32'h0);
    irq_chk(1'b0, 3, 1'b0);
    $display("Test peaks done");
    repeat (4100) @(posedge clock);
    bus(`LQM_IDX_PERIOD_FREQ, 1'b0, '0);
    check(rd >= 32'd199 && rd <= 32'd201, rd, 32'd200);
    bus(`LQM_IDX_SECOND_MODE, 1'b1, 32'h1);
    repeat (4100) @(posedge clock);
    bus(`LQM_IDX_PERIOD_FREQ, 1'b0, '0);
    check(rd >= 32'd32605 && rd <= 32'd32932, rd, 32'd32768);
    $display("Test period done");
    bus(`LQM_IDX_SAG_CYCLES, 1'b1, 32'h4);
    bus(`LQM_IDX_SUPPLY_ENABLE, 1'b1, 32'h1);
    bus(`LQM_IDX_SAG_LEVEL, 1'b1, 32'h2000);
    repeat (3800) @(posedge clock);
    check(si === 1'b0, si, 32'h0);
    irq_chk(1'b1, 4500, 1'b1);
    rd_chk(`LQM_IDX_SUPPLY_FLAGS, 32'h1);
    bus(`LQM_IDX_SAG_LEVEL, 1'b1, 32'h0);
    bus(`LQM_IDX_SUPPLY_FLAGS, 1'b1, 32'h0);
    irq_chk(1'b1, 3, 1'b0);
    $display("Test sag done");
    print_verdict();
  end
endmodule
